// ===== bplg_top.sv
// How it works
// R01 - In internal mode the backplane output is the oscillator pin frequency divided by 16.
// R02 - In internal mode the system wires the backplane output back to the backplane input.
// R03 - A grounded oscillator pin gives no edges, so the divider never steps.
// R04 - In external mode the backplane input is regenerated onto the backplane output.
// R05 - In external mode the outside party keeps a running clock on the backplane input.
// R06 - The active-low clear pin resets the block at once, without a clock edge.
// R07 - A load strobe copies the shift register contents into the segment latch.
// R08 - The first oscillator rising edge after reset selects the internal source for good.
// R09 - The backplane output is held low for as long as reset is asserted.
// R10 - Each segment output is its latched bit XORed with the backplane input.
// R11 - The divide counter is cleared by reset and restarts from zero on selection.
`include "bplg_defines.svh"

module bplg_top
  import bplg_pkg::*;
#(
  parameter int SEG_COUNT = `BPLG_SEG_COUNT
)
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic async_clear_low_i,
  input wire logic rc_timing_pin_i,
  input wire logic backplane_in_i,
  input wire logic [SEG_COUNT-1:0] shift_data_i,
  input wire logic load_strobe_i,
  output logic backplane_out_o,
  output logic internal_source_o,
  output logic [SEG_COUNT-1:0] segment_o
);

  // a change counts only once the second and third stages agree
  function automatic logic filtered(input logic s2, input logic s3, input logic prev);
    filtered = (s2 == s3) ? s3 : prev;
  endfunction

  logic rst_req;
  logic rst_meta;
  logic rst_int;
  logic osc_meta;
  logic osc_s2;
  logic osc_s3;
  logic osc_level;
  logic bpl_meta;
  logic bpl_s2;
  logic bpl_s3;
  logic bpl_level;
  logic [SEG_COUNT-1:0] seg_latch;

  bplg_gen_if gen_link();

  ////////////////////////////////////////////////////////////////////
  // assert at once, release on the clock so no flop sees a runt release
  assign rst_req = sys_rst_i | ~async_clear_low_i; // [R06]

  always_ff @(posedge clk_sys_i or posedge rst_req)
  begin
    if (rst_req)
    begin
      rst_meta <= 1'b1; // [R06]
      rst_int <= 1'b1;
    end
    else
    begin
      rst_meta <= 1'b0;
      rst_int <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys_i or posedge rst_int)
  begin
    if (rst_int)
    begin
      osc_meta <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
    end
    else
    begin
      osc_meta <= rc_timing_pin_i;
      osc_s2 <= osc_meta;
      osc_s3 <= osc_s2;
    end
  end

  // a one-clock glitch on the pin never reaches the divider
  always_ff @(posedge clk_sys_i or posedge rst_int)
  begin
    if (rst_int)
    begin
      osc_level <= 1'b0;
    end
    else
    begin
      osc_level <= filtered(osc_s2, osc_s3, osc_level);
    end
  end

  // loops back from our own output in internal mode
  always_ff @(posedge clk_sys_i or posedge rst_int)
  begin
    if (rst_int)
    begin
      bpl_meta <= 1'b0;
      bpl_s2 <= 1'b0;
      bpl_s3 <= 1'b0;
    end
    else
    begin
      bpl_meta <= backplane_in_i;
      bpl_s2 <= bpl_meta;
      bpl_s3 <= bpl_s2;
    end
  end

  // segments and regenerated output share this one filtered level
  always_ff @(posedge clk_sys_i or posedge rst_int)
  begin
    if (rst_int)
    begin
      bpl_level <= 1'b0;
    end
    else
    begin
      bpl_level <= filtered(bpl_s2, bpl_s3, bpl_level);
    end
  end

  assign gen_link.osc_level = osc_level;
  assign gen_link.bpl_level = bpl_level;

  bplg_backplane_gen u_gen
  (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_int),
    .gen(gen_link.gen)
  );

  assign backplane_out_o = gen_link.bp_out;
  assign internal_source_o = gen_link.internal_sel;

  ////////////////////////////////////////////////////////////////////
  // cleared latch keeps every segment dark after power-on
  always_ff @(posedge clk_sys_i or posedge rst_int)
  begin
    if (rst_int)
    begin
      seg_latch <= {SEG_COUNT{`BPLG_SEG_RESET}};
    end
    else if (load_strobe_i)
    begin
      seg_latch <= shift_data_i; // [R07]
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_int)
  begin
    if (rst_int)
    begin
      segment_o <= {SEG_COUNT{`BPLG_SEG_RESET}};
    end
    else
    begin
      segment_o <= seg_latch ^ {SEG_COUNT{bpl_level}}; // [R10]
    end
  end

endmodule

// ===== bplg_defines.svh
`ifndef BPLG_DEFINES_SVH
`define BPLG_DEFINES_SVH

// backplane period in oscillator periods
`define BPLG_DIV_RATIO 16
// oscillator rising edges per backplane half period, minus one
`define BPLG_HALF_LAST 3'h7
`define BPLG_HALF_WIDTH 3
// default number of segment outputs
`define BPLG_SEG_COUNT 46
// reset values
`define BPLG_BP_RESET 1'h0
`define BPLG_SEG_RESET 1'h0

`endif

// ===== bplg_pkg.sv
package bplg_pkg;

  typedef enum logic [0:0]
  {
    BPLG_EXTERNAL = 1'b0,
    BPLG_INTERNAL = 1'b1
  } bplg_mode_type;

endpackage

// ===== bplg_gen_if.sv
interface bplg_gen_if;
  logic osc_level;
  logic bpl_level;
  logic bp_out;
  logic internal_sel;

  modport core
  (
    output osc_level,
    output bpl_level,
    input bp_out,
    input internal_sel
  );

  modport gen
  (
    input osc_level,
    input bpl_level,
    output bp_out,
    output internal_sel
  );
endinterface

// ===== bplg_backplane_gen.sv
`include "bplg_defines.svh"

module bplg_backplane_gen
  import bplg_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  bplg_gen_if.gen gen
);

  bplg_mode_type mode;
  logic osc_prev;
  logic [`BPLG_HALF_WIDTH-1:0] half_count;
  logic bp_div;
  logic osc_rise;

  assign osc_rise = gen.osc_level & ~osc_prev;

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      osc_prev <= 1'b0;
    end
    else
    begin
      osc_prev <= gen.osc_level;
    end
  end

  // selection is sticky until the next reset
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mode <= BPLG_EXTERNAL;
    end
    else
    begin
      case (mode)
        BPLG_EXTERNAL:
        begin
          if (osc_rise)
          begin
            mode <= BPLG_INTERNAL; // [R08]
          end
        end
        default:
        begin
          mode <= BPLG_INTERNAL;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // divider only steps on oscillator edges, so a grounded pin freezes it
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      half_count <= '0; // [R11]
      bp_div <= `BPLG_BP_RESET;
    end
    else if (mode == BPLG_EXTERNAL)
    begin
      half_count <= '0; // [R11]
      bp_div <= `BPLG_BP_RESET;
    end
    else if (osc_rise) // [R03]
    begin
      if (half_count == `BPLG_HALF_LAST)
      begin
        half_count <= '0;
        bp_div <= ~bp_div; // [R01]
      end
      else
      begin
        half_count <= half_count + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      gen.bp_out <= `BPLG_BP_RESET; // [R09]
    end
    else if (mode == BPLG_INTERNAL)
    begin
      gen.bp_out <= bp_div; // [R01]
    end
    else
    begin
      gen.bp_out <= gen.bpl_level; // [R04] [R08]
    end
  end

  assign gen.internal_sel = (mode == BPLG_INTERNAL);

endmodule

// ===== bplg_asserts.sv
module bplg_checker #(parameter int SEG_COUNT = 46)
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic async_clear_low_i,
  input wire logic rc_timing_pin_i,
  input wire logic backplane_in_i,
  input wire logic [SEG_COUNT-1:0] shift_data_i,
  input wire logic load_strobe_i,
  input wire logic backplane_out_o,
  input wire logic internal_source_o,
  input wire logic [SEG_COUNT-1:0] segment_o
);
  timeunit 1ns;
  timeprecision 1ns;
  wire rst = sys_rst_i || !async_clear_low_i;
  logic [3:0] up;
  wire ok = &up;
  // synchronisers hold reset values for a while after release
  always_ff @(posedge clk_sys_i or posedge rst)
  begin
    if (rst)
      up <= '0;
    else if (!ok)
      up <= up + 4'h1;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst);
  sequence sel_rise;
    $rose(internal_source_o);
  endsequence
  bp_stop_a: assert property (disable iff (1'b0) rst |-> !backplane_out_o)
    else $error("bp runs in reset");
  seg_clear_a: assert property (disable iff (1'b0) rst |-> segment_o == '0)
    else $error("seg not cleared");
  sel_cause_a: assert property (sel_rise |-> $past(rc_timing_pin_i, 5))
    else $error("select without osc");
  sel_hold_a: assert property (internal_source_o |=> internal_source_o)
    else $error("select lost");
  first_low_a: assert property (sel_rise |=> !backplane_out_o)
    else $error("first half high");
  ext_follow_a: assert property (ok && !internal_source_o |->
    backplane_out_o == $past(backplane_in_i, 5)) else $error("bp not regenerated");
  seg_load_a: assert property (ok && $past(load_strobe_i, 2) |-> segment_o ==
    ($past(shift_data_i, 2) ^ {SEG_COUNT{$past(backplane_in_i, 5)}})) else $error("bad load");
  seg_flip_a: assert property (ok && !$past(load_strobe_i, 2) |-> (segment_o ^ $past(segment_o))
    == {SEG_COUNT{$past(backplane_in_i, 5) ^ $past(backplane_in_i, 6)}}) else $error("bad xor");
endmodule

// ===== bplg_panel_model.sv
module bplg_panel_model
  import bplg_pkg::*;
(
  input wire logic clk_i,
  input wire bplg_mode_type mode_i,
  input wire logic bp_out_i,
  output logic osc_o,
  output logic bpl_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] tick = '0;
  wire int_mode = mode_i == BPLG_INTERNAL;
  always @(posedge clk_i)
    tick <= tick + 5'h1;
  // pin grounded outside internal mode
  assign osc_o = int_mode && tick[2];
  // never static outside internal mode: the panel must not see dc
  assign bpl_o = int_mode ? bp_out_i : tick[4];
endmodule

// ===== bplg_top_tb.sv
module bplg_top_tb
  import bplg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int N = 46;
  localparam logic [N-1:0] PAT = {23{2'b10}};
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic clear_low = 1'b1;
  logic load = 1'b0;
  logic [N-1:0] data = '0;
  bplg_mode_type mode = BPLG_EXTERNAL;
  wire osc, bpl, bpo, sel;
  wire [N-1:0] seg;
  int fail_count = 0;
  int tests_run = 0;
  // backplane pin as the first sync stage saw it, newest in bit 0
  logic [4:0] bpl_hist = '0;
  always @(posedge clk_sys_i)
    bpl_hist <= {bpl_hist[3:0], bpl};
  initial forever #10 clk_sys_i = ~clk_sys_i;
  bplg_top dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .async_clear_low_i(clear_low),
    .rc_timing_pin_i(osc), .backplane_in_i(bpl), .shift_data_i(data), .load_strobe_i(load),
    .backplane_out_o(bpo), .internal_source_o(sel), .segment_o(seg));
  bplg_panel_model lcd (.clk_i(clk_sys_i), .mode_i(mode), .bp_out_i(bpo), .osc_o(osc),
    .bpl_o(bpl));
  ////////////////////////////////////////
  task automatic check(input logic [N-1:0] got, input logic [N-1:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic edges(input int n, output int e);
    logic p;
    e = 0;
    p = bpo;
    repeat (n)
    begin
      tick(1);
      e += int'(bpo !== p);
      p = bpo;
    end
  endtask
  task automatic wait_bp_high;
    for (int i = 0; i < 200 && bpo !== 1'b1; i++)
      tick(1);
  endtask
  task automatic t_external;
    int e;
    tick(40);
    check(N'(sel), '0);
    edges(64, e);
    check(N'(e), N'(4));
    repeat (32)
    begin
      tick(1);
      check(N'(bpo), N'(bpl_hist[4]));
    end
    $display("external done");
  endtask
  task automatic t_load;
    data <= PAT;
    load <= 1'b1;
    tick(1);
    data <= ~PAT;
    tick(1);
    load <= 1'b0;
    tick(8);
    check(seg, ~PAT ^ {N{bpl_hist[4]}});
    // a full backplane period, so both phases of the xor are seen
    repeat (32)
    begin
      tick(1);
      check(seg, ~PAT ^ {N{bpl_hist[4]}});
    end
    $display("load done");
  endtask
  task automatic t_internal;
    int e;
    int n;
    clear_low <= 1'b0;
    mode <= BPLG_INTERNAL;
    tick(8);
    clear_low <= 1'b1;
    for (int i = 0; i < 100 && sel !== 1'b1; i++)
      tick(1);
    check(N'(sel), N'(1));
    wait_bp_high();
    // model oscillator period of 8 clocks times half the divide ratio
    n = 0;
    while (bpo === 1'b1 && n < 200)
    begin
      tick(1);
      n++;
    end
    check(N'(n), N'(64));
    edges(250, e);
    check(N'(e), N'(3));
    wait_bp_high();
    clear_low <= 1'b0;
    #1;
    check(N'({bpo, sel}), '0);
    tick(8);
    check(N'(bpo), '0);
    clear_low <= 1'b1;
    $display("internal done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d fails %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    tick(8);
    sys_rst_i <= 1'b0;
    tick(4);
    t_external();
    t_load();
    t_internal();
    tally_and_finish();
  end
  // whole run is under a thousand cycles
  initial
  begin
    tick(3000);
    fail_count++;
    tally_and_finish();
  end
endmodule
bind bplg_top bplg_checker #(.SEG_COUNT(SEG_COUNT)) chk (.clk_sys_i, .sys_rst_i,
  .async_clear_low_i, .rc_timing_pin_i, .backplane_in_i, .shift_data_i, .load_strobe_i,
  .backplane_out_o, .internal_source_o, .segment_o);
